/* File: hw/dbmld_decoder.sv */
/*
 instruction decoder for branch, bit test, block move, block config,
 aux compare, data move, port input and accumulator load opcodes.
 assumes the fetch path presents one word per cycle with a valid strobe
 on the core clock; any second word follows its first word.
*/
`timescale 1ns/1ps

module dbmld_decoder (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic rst_i,
  // fetch stream
  input wire logic word_valid_i,
  input wire logic [15:0] word_i,
  // decoded instruction
  output dbmld_pkg::dbmld_dec_type dec_o,
  output logic illegal_o
);
  import dbmld_pkg::*;

  dbmld_state_type state_reg, state_next;
  dbmld_dec_type pend_reg, pend_next;
  dbmld_dec_type dec_reg, dec_next;
  logic illegal_reg, illegal_next;
  dbmld_dec_type cur;

  // first-word classification
  always_comb
  begin
    cur = '0;
    cur.indirect = word_i[ADDR_IND_BIT];
    cur.addr = word_i[6:0];
    cur.words = 2'h1;
    cur.cyc_true = CYC_ONE;
    cur.cyc_false = CYC_ONE;
    if (word_i == OPC_BR_ACC_NZ)
      cur.op = OP_BR_NZ;
    else if (word_i == OPC_BR_ACC_Z)
      cur.op = OP_BR_Z;
    else if (word_i == OPC_BR_OVF)
      cur.op = OP_BR_OVF;
    else if (word_i == OPC_CFG_DATA)
      cur.op = OP_CFG_DATA;
    else if (word_i[15:4] == PFX_AUX_CMP && word_i[3:2] == AUX_CMP_FIXED)
      cur.op = OP_AUX_CMP;
    else if (word_i[15:4] == PFX_LOAD_LONG)
      cur.op = OP_LOAD_LONG;
    else if (word_i[15:8] == PFX_TEST_BIT_OPREG)
      cur.op = OP_TEST_BIT_OPREG;
    else if (word_i[15:8] == PFX_LOAD_HIGH)
      cur.op = OP_LOAD_HIGH;
    else if (word_i[15:8] == PFX_COPY_SRC_IMM)
      cur.op = OP_COPY_SRC_IMM;
    else if (word_i[15:8] == PFX_COPY_DST_IMM)
      cur.op = OP_COPY_DST_IMM;
    else if (word_i[15:8] == PFX_PROG_COPY)
      cur.op = OP_PROG_COPY;
    else if (word_i[15:8] == PFX_PORT_IN)
      cur.op = OP_PORT_IN;
    // data move; other 0x7 codes belong to other decoders
    else if (word_i[15:8] == PFX_DATA_MOVE_B)
      cur.op = OP_DATA_MOVE;
    else if (word_i[15:12] == PFX_LOAD_SHIFT)
      cur.op = OP_LOAD_SHIFT;
    // shift count sits above the operand address, or in bits 3:0 for the long load
    cur.shift = word_i[SHIFT_LSB +: 4];
    if (cur.op == OP_LOAD_LONG)
      cur.shift = word_i[3:0];
    cur.cmp_cond = word_i[1:0];
    unique case (cur.op)
      OP_BR_NZ, OP_BR_Z, OP_BR_OVF:
      begin
        cur.words = 2'h2;
        cur.cyc_true = CYC_FOUR;
        cur.cyc_false = CYC_TWO;
        cur.is_cond = 1'b1;
      end
      OP_COPY_SRC_IMM, OP_COPY_DST_IMM, OP_PROG_COPY:
      begin
        cur.words = 2'h2;
        cur.cyc_true = CYC_THREE;
        cur.cyc_false = CYC_THREE;
      end
      OP_PORT_IN, OP_LOAD_LONG:
      begin
        cur.words = 2'h2;
        cur.cyc_true = CYC_TWO;
        cur.cyc_false = CYC_TWO;
      end
      default:
      begin
        cur.words = 2'h1;
      end
    endcase
    // opcodes with no operand address report indirect and addr cleared
    if (cur.op == OP_LOAD_LONG || cur.op == OP_AUX_CMP ||
        cur.is_cond || cur.op == OP_CFG_DATA || cur.op == OP_NONE)
    begin
      cur.indirect = 1'b0;
      cur.addr = 7'h00;
    end
  end

  // two-word sequencing
  always_comb
  begin
    state_next = state_reg;
    pend_next = pend_reg;
    dec_next = dec_reg;
    dec_next.valid = 1'b0;
    illegal_next = 1'b0;
    if (word_valid_i)
    begin
      unique case (state_reg)
        ST_FIRST:
        begin
          if (cur.op == OP_NONE)
            illegal_next = 1'b1;
          else if (cur.words == 2'h2)
          begin
            pend_next = cur;
            state_next = ST_SECOND;
          end
          else
          begin
            dec_next = cur;
            dec_next.valid = 1'b1;
          end
        end
        ST_SECOND:
        begin
          dec_next = pend_reg;
          dec_next.imm = word_i;
          dec_next.valid = 1'b1;
          state_next = ST_FIRST;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
    begin
      state_reg <= ST_FIRST;
      pend_reg <= '0;
      dec_reg <= '0;
      illegal_reg <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      pend_reg <= pend_next;
      dec_reg <= dec_next;
      illegal_reg <= illegal_next;
    end
  end

  assign dec_o = dec_reg;
  assign illegal_o = illegal_reg;

  a_branch_cycles: assert property (@(posedge core_clk_i) disable iff (rst_i)
    dec_o.valid && dec_o.is_cond |-> dec_o.cyc_true == CYC_FOUR &&
      dec_o.cyc_false == CYC_TWO && dec_o.words == 2'h2)
    else $error("branch cycle counts wrong");

  a_zero_branch: assert property (@(posedge core_clk_i) disable iff (rst_i)
    state_reg == ST_FIRST && word_valid_i && word_i == OPC_BR_ACC_Z
    ##1 word_valid_i |=> dec_o.valid && dec_o.op == OP_BR_Z &&
      dec_o.imm == $past(word_i))
    else $error("zero branch not decoded");

  a_bit_test: assert property (@(posedge core_clk_i) disable iff (rst_i)
    state_reg == ST_FIRST && word_valid_i &&
      word_i[15:8] == PFX_TEST_BIT_OPREG
    |=> dec_o.valid && dec_o.op == OP_TEST_BIT_OPREG && dec_o.words == 2'h1)
    else $error("bit test not decoded in one cycle");

  a_copy_imm: assert property (@(posedge core_clk_i) disable iff (rst_i)
    state_reg == ST_FIRST && word_valid_i &&
      word_i[15:8] == PFX_COPY_SRC_IMM
    |=> !dec_o.valid && state_reg == ST_SECOND)
    else $error("copy did not wait for second word");

  a_copy_cycles: assert property (@(posedge core_clk_i) disable iff (rst_i)
    dec_o.valid && (dec_o.op == OP_COPY_DST_IMM ||
      dec_o.op == OP_PROG_COPY) |-> dec_o.cyc_true == CYC_THREE)
    else $error("copy cycle count wrong");

  a_cfg_data: assert property (@(posedge core_clk_i) disable iff (rst_i)
    state_reg == ST_FIRST && word_valid_i &&
      word_i == OPC_CFG_DATA |=> dec_o.valid && dec_o.op == OP_CFG_DATA)
    else $error("configure block not decoded");

  a_load_shift: assert property (@(posedge core_clk_i) disable iff (rst_i)
    state_reg == ST_FIRST && word_valid_i &&
      word_i[15:12] == PFX_LOAD_SHIFT
    |=> dec_o.op == OP_LOAD_SHIFT && dec_o.shift == $past(word_i[11:8]))
    else $error("load shift field wrong");

  a_addr_mode: assert property (@(posedge core_clk_i) disable iff (rst_i)
    state_reg == ST_FIRST && word_valid_i &&
      word_i[15:8] == PFX_LOAD_HIGH
    |=> dec_o.indirect == $past(word_i[7]) && dec_o.addr == $past(word_i[6:0]))
    else $error("operand address mode wrong");

endmodule : dbmld_decoder

/* File: hw/dbmld_pkg.sv */
/*
 decode package: opcode patterns, field positions, instruction classes,
 word and cycle counts for the branch/move/load decoder.
 assumes a 16-bit instruction word stream from the fetch path.
*/
package dbmld_pkg;

  localparam int WORD_W = 16;

  // fixed full-word opcodes
  localparam logic [15:0] OPC_BR_ACC_NZ = 16'hE308;
  localparam logic [15:0] OPC_BR_ACC_Z = 16'hE388;
  localparam logic [15:0] OPC_BR_OVF = 16'hE322;
  localparam logic [15:0] OPC_CFG_DATA = 16'hBE44;
  // high-order prefixes, and the fixed aux compare field in bits 3:2
  localparam logic [7:0] PFX_TEST_BIT_OPREG = 8'h6F;
  localparam logic [7:0] PFX_COPY_SRC_IMM = 8'hA8;
  localparam logic [7:0] PFX_COPY_DST_IMM = 8'hA9;
  localparam logic [7:0] PFX_PROG_COPY = 8'hA5;
  localparam logic [7:0] PFX_PORT_IN = 8'hAF;
  localparam logic [7:0] PFX_LOAD_HIGH = 8'h6A;
  localparam logic [3:0] PFX_DATA_MOVE_HI = 4'h7;
  localparam logic [7:0] PFX_DATA_MOVE_B = 8'h77;
  localparam logic [3:0] PFX_LOAD_SHIFT = 4'h1;
  localparam logic [11:0] PFX_LOAD_LONG = 12'hBF8;
  localparam logic [11:0] PFX_AUX_CMP = 12'hBF4;
  localparam logic [1:0] AUX_CMP_FIXED = 2'h1;

  // field positions
  localparam int ADDR_LSB = 0;
  localparam int ADDR_IND_BIT = 7;
  localparam int SHIFT_LSB = 8;

  // word/cycle figures
  localparam logic [2:0] CYC_ONE = 3'h1;
  localparam logic [2:0] CYC_TWO = 3'h2;
  localparam logic [2:0] CYC_THREE = 3'h3;
  localparam logic [2:0] CYC_FOUR = 3'h4;

  typedef enum logic [3:0] {
    OP_NONE = 4'h0,
    OP_BR_NZ = 4'h1,
    OP_BR_Z = 4'h2,
    OP_BR_OVF = 4'h3,
    OP_TEST_BIT_OPREG = 4'h4,
    OP_COPY_SRC_IMM = 4'h5,
    OP_COPY_DST_IMM = 4'h6,
    OP_PROG_COPY = 4'h7,
    OP_CFG_DATA = 4'h8,
    OP_AUX_CMP = 4'h9,
    OP_DATA_MOVE = 4'hA,
    OP_PORT_IN = 4'hB,
    OP_LOAD_SHIFT = 4'hC,
    OP_LOAD_LONG = 4'hD,
    OP_LOAD_HIGH = 4'hE
  } dbmld_op_type;

  typedef enum logic [0:0] {
    ST_FIRST = 1'b0,
    ST_SECOND = 1'b1
  } dbmld_state_type;

  typedef struct packed {
    logic valid;
    dbmld_op_type op;
    logic indirect;
    logic [6:0] addr;
    logic [3:0] shift;
    logic [1:0] cmp_cond;
    logic [15:0] imm;
    logic [1:0] words;
    logic [2:0] cyc_true;
    logic [2:0] cyc_false;
    logic is_cond;
  } dbmld_dec_type;

endpackage : dbmld_pkg

/* File: tb/dbmld_fetch_model.sv */
/*
 fetch path model: offers instruction words to the decoder one per edge.
 assumes the caller stands at a falling clock edge when it calls a task.
*/
`timescale 1ns/1ps

module dbmld_fetch_model (
  // clock
  input wire logic core_clk_i,
  // fetch stream
  output logic word_valid_o,
  output logic [15:0] word_o
);
  initial
  begin
    word_valid_o = 1'b0;
    word_o = 16'h0000;
  end

  // word held over one rising edge; caller releases it with idle
  task put(input logic [15:0] w);
    word_valid_o = 1'b1;
    word_o = w;
    @(posedge core_clk_i);
    @(negedge core_clk_i);
  endtask : put

  // stalled bus shows a pattern that changes every cycle
  task idle(input int n);
    repeat (n)
    begin
      word_valid_o = 1'b0;
      word_o = ~word_o;
      @(negedge core_clk_i);
    end
  endtask : idle
endmodule : dbmld_fetch_model

/* File: tb/dsp_branch_move_load_decoder_bench.sv */
/*
 bench for the branch/move/load decoder: feeds words through the fetch
 model and compares decoded fields. assumes no other stimulus.
*/
`timescale 1ns/1ps

module dsp_branch_move_load_decoder_bench;
  import dbmld_pkg::*;
  logic core_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic word_valid_i;
  logic [15:0] word_i;
  dbmld_dec_type dec_o;
  logic illegal_o;
  int errors = 0;
  int n_compared = 0;
  int cycles = 0;
  localparam logic [15:0] TW [5] = '{16'hA815, 16'hA99A, 16'hA5C3,
    16'hAF7E, 16'hBF85};
  localparam dbmld_op_type TO [5] = '{OP_COPY_SRC_IMM, OP_COPY_DST_IMM,
    OP_PROG_COPY, OP_PORT_IN, OP_LOAD_LONG};
  localparam logic [2:0] TC [5] = '{3'h3, 3'h3, 3'h3, 3'h2, 3'h2};
  localparam logic [15:0] SW [7] = '{16'h6F85, 16'hBE44, 16'hBF45,
    16'hBF47, 16'h7707, 16'h1C33, 16'h6AFF};
  localparam dbmld_op_type SO [7] = '{OP_TEST_BIT_OPREG, OP_CFG_DATA,
    OP_AUX_CMP, OP_AUX_CMP, OP_DATA_MOVE, OP_LOAD_SHIFT, OP_LOAD_HIGH};

  always #5 core_clk_i = ~core_clk_i;

  dbmld_decoder i_dbmld_decoder (.core_clk_i(core_clk_i), .rst_i(rst_i),
    .word_valid_i(word_valid_i), .word_i(word_i), .dec_o(dec_o),
    .illegal_o(illegal_o));
  dbmld_fetch_model i_dbmld_fetch_model (.core_clk_i(core_clk_i),
    .word_valid_o(word_valid_i), .word_o(word_i));

  task check(input string what, input logic [15:0] seen, exp);
    n_compared++;
    if (seen !== exp)
    begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // looked at in the one cycle that the valid pulse stands
  task expect_dec(input dbmld_op_type op, input logic [1:0] words,
    input logic [2:0] ct, input logic [15:0] imm);
    check("valid", dec_o.valid, 1'b1);
    check("op", dec_o.op, op);
    check("words", dec_o.words, words);
    check("cyc_true", dec_o.cyc_true, ct);
    if (words == 2'h2)
      check("imm", dec_o.imm, imm);
  endtask : expect_dec

  task two(input logic [15:0] w1, w2, input int gap);
    i_dbmld_fetch_model.put(w1);
    check("early", dec_o.valid, 1'b0);
    i_dbmld_fetch_model.idle(gap);
    i_dbmld_fetch_model.put(w2);
  endtask : two

  task t_branches;
    two(16'hE308, 16'h1234, 0);
    expect_dec(OP_BR_NZ, 2'h2, 3'h4, 16'h1234);
    check("cyc_false", dec_o.cyc_false, 3'h2);
    check("is_cond", dec_o.is_cond, 1'b1);
    i_dbmld_fetch_model.idle(1);
    check("pulse", dec_o.valid, 1'b0);
    // second word delayed by a stall
    two(16'hE388, 16'hEDCB, 3);
    expect_dec(OP_BR_Z, 2'h2, 3'h4, 16'hEDCB);
    check("cyc_false", dec_o.cyc_false, 3'h2);
  endtask : t_branches

  // second words look like opcodes: they must still be taken as data
  task t_moves;
    for (int k = 0; k < 5; k++)
    begin
      two(TW[k], 16'h6F00 + 16'(k), 0);
      expect_dec(TO[k], 2'h2, TC[k], 16'h6F00 + 16'(k));
      if (k < 4)
        check("addr", {dec_o.indirect, dec_o.addr}, TW[k][7:0]);
    end
    check("shift", dec_o.shift, 4'h5);
  endtask : t_moves

  task t_singles;
    for (int k = 0; k < 7; k++)
    begin
      i_dbmld_fetch_model.put(SW[k]);
      expect_dec(SO[k], 2'h1, 3'h1, 16'h0000);
      check("is_cond", dec_o.is_cond, 1'b0);
      if (SW[k][15:12] != 4'hB)
        check("addr", {dec_o.indirect, dec_o.addr}, SW[k][7:0]);
      if (SO[k] == OP_AUX_CMP)
        check("cmp", dec_o.cmp_cond, SW[k][1:0]);
      if (SO[k] == OP_LOAD_SHIFT)
        check("shift", dec_o.shift, SW[k][11:8]);
    end
  endtask : t_singles

  task t_illegal;
    i_dbmld_fetch_model.put(16'hFFFF);
    check("illegal", illegal_o, 1'b1);
    check("valid", dec_o.valid, 1'b0);
    // a move code outside this decoder's data move form
    i_dbmld_fetch_model.put(16'h7300);
    check("illegal", illegal_o, 1'b1);
    i_dbmld_fetch_model.put(16'h7701);
    expect_dec(OP_DATA_MOVE, 2'h1, 3'h1, 16'h0000);
    check("illegal", illegal_o, 1'b0);
  endtask : t_illegal

  // reset between the two words drops the half-taken branch
  task t_reset;
    i_dbmld_fetch_model.put(16'hE388);
    rst_i = 1'b1;
    i_dbmld_fetch_model.idle(2);
    check("rst", dec_o.valid, 1'b0);
    rst_i = 1'b0;
    i_dbmld_fetch_model.put(16'h6A01);
    expect_dec(OP_LOAD_HIGH, 2'h1, 3'h1, 16'h0000);
  endtask : t_reset

  task summarize;
    $display("compared %0d errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : summarize

  // ceiling well above the fifty or so cycles the run needs
  always @(posedge core_clk_i)
  begin
    cycles++;
    if (cycles == 2000)
    begin
      errors++;
      summarize();
    end
  end

  initial
  begin
    repeat (16) @(negedge core_clk_i);
    rst_i = 1'b0;
    t_branches();
    t_moves();
    t_singles();
    t_illegal();
    t_reset();
    summarize();
  end
endmodule : dsp_branch_move_load_decoder_bench
